// ==== verilog/poc_top.sv ====
// Purpose: parameter protection, bus settings and position output shaping
// Assumes: inputs synchronous to MCLK; distance and velocity in um and um/s
// Notes: outputs update after two divisions following a good sample
`timescale 1ns/1ps
`default_nettype none
module poc_top #(
  parameter int TICK_CYC = poc_pkg::TICK_CYC // Cycles per millisecond
) (
  input wire logic MCLK, // 20 MHz clock
  input wire logic RESET_N, // Async reset, low
  input wire logic CE, // Clock enable
  input wire logic PAR_WR, // Parameter write strobe
  input wire logic PAR_BUS, // Write comes from field bus
  input wire logic [4:0] PAR_ID, // Parameter id
  input wire logic [31:0] PAR_DATA, // Parameter value
  input wire logic MEAS_VALID, // New sample strobe
  input wire logic MEAS_ERR, // Sample is implausible
  input wire logic [31:0] MEAS_DIST, // Distance, um, signed
  input wire logic [31:0] MEAS_VEL, // Velocity, um/s, signed
  input wire logic [1:0] SW_IN, // Switching inputs
  output logic [31:0] POS_OUT, // Scaled position
  output logic [31:0] VEL_OUT, // Scaled velocity
  output logic OUT_VALID, // New output pulse
  output logic POS_ERR, // Error handling active
  output logic PAR_EN, // Parameter enable, high = enabled
  output logic PW_OK, // Password matched
  output logic PAR_REJ, // Write refused pulse
  output logic LANG_EN, // English selected pulse
  output logic [2:0] BAUD_SEL, // Bit rate code
  output logic [6:0] NODE_ID, // Bus node address
  output logic BUS_ACT, // Bus interface on
  output logic UNIT_INCH, // Inch unit selected
  output logic LASER_ON // Laser enable
);
  ////////////////////////////////////////////////////////////////////////////
  // Configuration
  logic en_q, en_d, pwon_q, pwon_d, unl_q, unl_d, rej_q, rej_d, lang_q, lang_d;
  logic [15:0] pw_q, pw_d, free_q, free_d, edms_q, edms_d;
  logic [2:0] baud_q, baud_d, pres_q, pres_d, vres_q, vres_d;
  logic unit_q, unit_d, dir_q, dir_d, edon_q, edon_d, esub_q, esub_d, bus_q, bus_d;
  logic [31:0] offs_q, offs_d, pset_q, pset_d, pcor_q, pcor_d;
  logic pact_q, pact_d, laser_q, laser_d;
  logic [6:0] node_q, node_d;
  logic [1:0] fn_q [2];
  logic [1:0] fn_d [2];
  logic [1:0] pol_q, pol_d, act_prev_q, act_prev_d, act;
  logic menu_ok, pv_id, ok, teach;
  logic [31:0] raw_q, unit_um, pset_um;

  assign act = SW_IN ^ ~pol_q; // Active level per polarity, 0 = low active
  assign unit_um = unit_q ? poc_pkg::UM_PER_CIN : poc_pkg::UM_PER_MM;
  assign pset_um = 32'(pset_q * unit_um);

  // Access check, parameter writes, teach and defaults
  always_comb begin
    en_d = en_q;
    pwon_d = pwon_q;
    unl_d = unl_q;
    pw_d = pw_q;
    baud_d = baud_q;
    pres_d = pres_q;
    vres_d = vres_q;
    unit_d = unit_q;
    dir_d = dir_q;
    offs_d = offs_q;
    pset_d = pset_q;
    pcor_d = pcor_q;
    pact_d = pact_q;
    free_d = free_q;
    edon_d = edon_q;
    edms_d = edms_q;
    esub_d = esub_q;
    node_d = node_q;
    bus_d = bus_q;
    fn_d = fn_q;
    pol_d = pol_q;
    act_prev_d = act;
    rej_d = 1'b0;
    lang_d = 1'b0;
    laser_d = 1'b1;
    teach = 1'b0;
    menu_ok = en_q && (!pwon_q || unl_q);
    pv_id = (PAR_ID >= poc_pkg::ID_UNIT) && (PAR_ID <= poc_pkg::ID_ESUB);
    ok = PAR_BUS ? pv_id : (menu_ok || PAR_ID == poc_pkg::ID_PEN || PAR_ID == poc_pkg::ID_UNLOCK);
    for (int i = 0; i < 2; i++) begin
      if (fn_q[i] == poc_pkg::FN_LASER && act[i]) laser_d = 1'b0;
      if (fn_q[i] == poc_pkg::FN_PRESET && act[i] && !act_prev_q[i]) teach = 1'b1;
    end
    if (teach) begin
      pact_d = 1'b1; // Preset replaces offset from now on
      pcor_d = pset_um - raw_q;
    end
    if (PAR_WR && !ok) rej_d = 1'b1;
    if (PAR_WR && ok) begin
      case (PAR_ID)
        poc_pkg::ID_PEN: begin
          en_d = PAR_DATA[0];
          if (!PAR_DATA[0]) unl_d = 1'b0;
        end
        poc_pkg::ID_PWON: begin
          pwon_d = PAR_DATA[0];
          unl_d = 1'b1;
        end
        poc_pkg::ID_PWDIG: begin
          if (PAR_DATA[3:0] > 4'h9) rej_d = 1'b1;
          else pw_d[{PAR_DATA[5:4], 2'b00} +: 4] = PAR_DATA[3:0];
        end
        poc_pkg::ID_UNLOCK: begin
          if (en_q && (PAR_DATA[15:0] == pw_q || PAR_DATA[15:0] == poc_pkg::MASTER_PW)) unl_d = 1'b1;
          else rej_d = 1'b1;
        end
        poc_pkg::ID_BAUD: begin
          if (PAR_DATA[2:0] > poc_pkg::BAUD_MAX || PAR_DATA[31:3] != 29'h00000000) rej_d = 1'b1;
          else baud_d = PAR_DATA[2:0];
        end
        poc_pkg::ID_PRES: begin
          if (PAR_DATA[2:0] > poc_pkg::RES_FREE) rej_d = 1'b1;
          else pres_d = PAR_DATA[2:0];
        end
        poc_pkg::ID_VRES: begin
          if (PAR_DATA[2:0] > poc_pkg::RES_FREE) rej_d = 1'b1;
          else vres_d = PAR_DATA[2:0];
        end
        poc_pkg::ID_UNIT: unit_d = PAR_DATA[0];
        poc_pkg::ID_DIR: dir_d = PAR_DATA[0];
        poc_pkg::ID_OFFS: offs_d = PAR_DATA;
        poc_pkg::ID_PRESET: pset_d = PAR_DATA;
        poc_pkg::ID_FREE: begin
          if (PAR_DATA[31:16] != 16'h0000 || PAR_DATA[15:0] < poc_pkg::FREE_MIN ||
              PAR_DATA[15:0] > poc_pkg::FREE_MAX) rej_d = 1'b1;
          else free_d = PAR_DATA[15:0];
        end
        poc_pkg::ID_EDON: edon_d = PAR_DATA[0];
        poc_pkg::ID_EDMS: edms_d = PAR_DATA[15:0];
        poc_pkg::ID_ESUB: esub_d = PAR_DATA[0];
        poc_pkg::ID_NODE: begin
          if (PAR_DATA[6:0] == 7'h00 || PAR_DATA[31:7] != 25'h0000000) rej_d = 1'b1;
          else node_d = PAR_DATA[6:0];
        end
        poc_pkg::ID_BUSON: bus_d = PAR_DATA[0];
        poc_pkg::ID_IN0, poc_pkg::ID_IN1: begin
          if (PAR_DATA[1:0] == 2'h3) rej_d = 1'b1;
          else begin
            fn_d[PAR_ID[1]] = PAR_DATA[1:0];
            pol_d[PAR_ID[1]] = PAR_DATA[2];
          end
        end
        poc_pkg::ID_DEFLT: begin
          en_d = 1'b0; // Everything back to standard at once
          pwon_d = 1'b0;
          unl_d = 1'b0;
          pw_d = 16'h0000;
          baud_d = poc_pkg::BAUD_DEF;
          pres_d = poc_pkg::PRES_DEF;
          vres_d = poc_pkg::VRES_DEF;
          unit_d = 1'b0;
          dir_d = 1'b0;
          offs_d = 32'h00000000;
          pset_d = 32'h00000000;
          pcor_d = 32'h00000000;
          pact_d = 1'b0;
          free_d = poc_pkg::FREE_DEF;
          edon_d = 1'b1;
          edms_d = poc_pkg::EDMS_DEF;
          esub_d = 1'b0;
          node_d = poc_pkg::NODE_DEF;
          bus_d = 1'b1;
          fn_d = '{poc_pkg::FN_NONE, poc_pkg::FN_NONE};
          pol_d = 2'b00;
          lang_d = 1'b1;
        end
        default: rej_d = 1'b1;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      en_q <= 1'b0;
      pwon_q <= 1'b0;
      unl_q <= 1'b0;
      pw_q <= 16'h0000;
      baud_q <= poc_pkg::BAUD_DEF;
      pres_q <= poc_pkg::PRES_DEF;
      vres_q <= poc_pkg::VRES_DEF;
      unit_q <= 1'b0;
      dir_q <= 1'b0;
      offs_q <= 32'h00000000;
      pset_q <= 32'h00000000;
      pcor_q <= 32'h00000000;
      pact_q <= 1'b0;
      free_q <= poc_pkg::FREE_DEF;
      edon_q <= 1'b1;
      edms_q <= poc_pkg::EDMS_DEF;
      esub_q <= 1'b0;
      node_q <= poc_pkg::NODE_DEF;
      bus_q <= 1'b1;
      fn_q <= '{poc_pkg::FN_NONE, poc_pkg::FN_NONE};
      pol_q <= 2'b00;
      act_prev_q <= 2'b00;
      rej_q <= 1'b0;
      lang_q <= 1'b0;
      laser_q <= 1'b1;
    end else if (CE) begin
      en_q <= en_d;
      pwon_q <= pwon_d;
      unl_q <= unl_d;
      pw_q <= pw_d;
      baud_q <= baud_d;
      pres_q <= pres_d;
      vres_q <= vres_d;
      unit_q <= unit_d;
      dir_q <= dir_d;
      offs_q <= offs_d;
      pset_q <= pset_d;
      pcor_q <= pcor_d;
      pact_q <= pact_d;
      free_q <= free_d;
      edon_q <= edon_d;
      edms_q <= edms_d;
      esub_q <= esub_d;
      node_q <= node_d;
      bus_q <= bus_d;
      fn_q <= fn_d;
      pol_q <= pol_d;
      act_prev_q <= act_prev_d;
      rej_q <= rej_d;
      lang_q <= lang_d;
      laser_q <= laser_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error delay handling
  poc_pkg::poc_es_t es_q, es_d;
  logic [15:0] ms_q, ms_d;
  logic [14:0] tick_q, tick_d;
  logic good, bad;
  assign good = MEAS_VALID && !MEAS_ERR;
  assign bad = MEAS_VALID && MEAS_ERR;

  // Hold, then substitute, after an implausible sample
  always_comb begin
    es_d = es_q;
    ms_d = ms_q;
    tick_d = tick_q;
    case (es_q)
      poc_pkg::ES_OK: begin
        ms_d = 16'h0000;
        tick_d = 15'h0000;
        if (bad) es_d = edon_q ? poc_pkg::ES_HOLD : poc_pkg::ES_SUBST;
      end
      poc_pkg::ES_HOLD: begin
        if (good) es_d = poc_pkg::ES_OK;
        else if (ms_q >= edms_q) es_d = poc_pkg::ES_SUBST;
        else if (tick_q == 15'(TICK_CYC - 1)) begin
          tick_d = 15'h0000;
          ms_d = ms_q + 16'h0001;
        end else tick_d = tick_q + 15'h0001;
      end
      poc_pkg::ES_SUBST: if (good) es_d = poc_pkg::ES_OK;
      default: es_d = poc_pkg::ES_OK;
    endcase
  end

  // Error registers
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      es_q <= poc_pkg::ES_OK;
      ms_q <= 16'h0000;
      tick_q <= 15'h0000;
    end else if (CE) begin
      es_q <= es_d;
      ms_q <= ms_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position and velocity scaling
  poc_pkg::poc_cs_t cs_q, cs_d;
  logic [31:0] pos_q, pos_d, vel_q, vel_d, praw_q, praw_d, vin_q, vin_d, raw_d, sum;
  logic [31:0] div_a, div_b, quot, pdiv, vdiv;
  logic ov_q, ov_d, div_go, div_done, psgn_q, psgn_d;

  // Divisor per selected step; free value used only when chosen
  always_comb begin
    case (pres_q)
      3'h0: pdiv = poc_pkg::PDIV_0;
      3'h1: pdiv = poc_pkg::PDIV_1;
      3'h2: pdiv = unit_q ? poc_pkg::UM_PER_CIN : poc_pkg::PDIV_2;
      3'h3: pdiv = poc_pkg::PDIV_3;
      default: pdiv = {16'h0000, free_q};
    endcase
    case (vres_q)
      3'h0: vdiv = poc_pkg::VDIV_0;
      3'h1: vdiv = poc_pkg::VDIV_1;
      3'h2: vdiv = poc_pkg::VDIV_2;
      3'h3: vdiv = poc_pkg::VDIV_3;
      default: vdiv = {16'h0000, free_q};
    endcase
  end

  // Correct, split sign, divide, restore sign
  always_comb begin
    cs_d = cs_q;
    pos_d = pos_q;
    vel_d = vel_q;
    praw_d = praw_q;
    vin_d = vin_q;
    psgn_d = psgn_q;
    raw_d = raw_q;
    ov_d = 1'b0;
    div_go = 1'b0;
    div_a = 32'h00000000;
    div_b = vdiv;
    raw_d = dir_q ? -MEAS_DIST : MEAS_DIST;
    sum = raw_d + (pact_q ? pcor_q : 32'(offs_q * unit_um));
    if (es_q == poc_pkg::ES_SUBST && !esub_q) pos_d = 32'h00000000;
    case (cs_q)
      poc_pkg::CS_IDLE: begin
        if (!good) raw_d = raw_q;
        else begin
          praw_d = sum;
          vin_d = dir_q ? -MEAS_VEL : MEAS_VEL;
          psgn_d = sum[31];
          div_go = 1'b1;
          div_a = sum[31] ? -sum : sum;
          div_b = pdiv;
          cs_d = poc_pkg::CS_POS;
        end
      end
      poc_pkg::CS_POS: begin
        raw_d = raw_q;
        if (div_done) begin
          praw_d = psgn_q ? -quot : quot;
          psgn_d = vin_q[31];
          div_go = 1'b1;
          div_a = vin_q[31] ? -vin_q : vin_q;
          cs_d = poc_pkg::CS_VEL;
        end
      end
      poc_pkg::CS_VEL: begin
        raw_d = raw_q;
        if (div_done) begin
          pos_d = praw_q;
          vel_d = psgn_q ? -quot : quot;
          ov_d = 1'b1;
          cs_d = poc_pkg::CS_IDLE;
        end
      end
      default: begin
        raw_d = raw_q;
        cs_d = poc_pkg::CS_IDLE;
      end
    endcase
  end

  // Scaling registers
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_q <= poc_pkg::CS_IDLE;
      pos_q <= 32'h00000000;
      vel_q <= 32'h00000000;
      praw_q <= 32'h00000000;
      vin_q <= 32'h00000000;
      psgn_q <= 1'b0;
      raw_q <= 32'h00000000;
      ov_q <= 1'b0;
    end else if (CE) begin
      cs_q <= cs_d;
      pos_q <= pos_d;
      vel_q <= vel_d;
      praw_q <= praw_d;
      vin_q <= vin_d;
      psgn_q <= psgn_d;
      raw_q <= raw_d;
      ov_q <= ov_d;
    end
  end

  // Shared divider
  poc_div u_div (
    .clk(MCLK),
    .rst_n(RESET_N),
    .ce(CE),
    .start(div_go),
    .dividend(div_a),
    .divisor(div_b),
    .done(div_done),
    .quot(quot)
  );

  // Outputs, all from flip-flops
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) POS_ERR <= 1'b0;
    else if (CE) POS_ERR <= (es_d != poc_pkg::ES_OK);
  end
  assign POS_OUT = pos_q;
  assign VEL_OUT = vel_q;
  assign OUT_VALID = ov_q;
  assign PAR_EN = en_q;
  assign PW_OK = unl_q;
  assign PAR_REJ = rej_q;
  assign LANG_EN = lang_q;
  assign BAUD_SEL = baud_q;
  assign NODE_ID = node_q;
  assign BUS_ACT = bus_q;
  assign UNIT_INCH = unit_q;
  assign LASER_ON = laser_q;
endmodule // poc_top
`default_nettype wire

// ==== inc/poc_pkg.sv ====
// Purpose: constants for the position output and parameter control block
// Assumes: one 20 MHz clock, distances in micrometres, velocities in um/s
// Notes: parameter ids select the target of a parameter write
package poc_pkg;
  // Parameter ids
  localparam logic [4:0] ID_PEN = 5'h00;
  localparam logic [4:0] ID_PWON = 5'h01;
  localparam logic [4:0] ID_PWDIG = 5'h02;
  localparam logic [4:0] ID_UNLOCK = 5'h03;
  localparam logic [4:0] ID_BAUD = 5'h04;
  localparam logic [4:0] ID_PRES = 5'h05;
  localparam logic [4:0] ID_VRES = 5'h06;
  localparam logic [4:0] ID_UNIT = 5'h07;
  localparam logic [4:0] ID_DIR = 5'h08;
  localparam logic [4:0] ID_OFFS = 5'h09;
  localparam logic [4:0] ID_PRESET = 5'h0A;
  localparam logic [4:0] ID_FREE = 5'h0B;
  localparam logic [4:0] ID_EDON = 5'h0C;
  localparam logic [4:0] ID_EDMS = 5'h0D;
  localparam logic [4:0] ID_ESUB = 5'h0E;
  localparam logic [4:0] ID_NODE = 5'h0F;
  localparam logic [4:0] ID_BUSON = 5'h10;
  localparam logic [4:0] ID_IN0 = 5'h11;
  localparam logic [4:0] ID_IN1 = 5'h12;
  localparam logic [4:0] ID_DEFLT = 5'h13;
  // Master code, BCD
  localparam logic [15:0] MASTER_PW = 16'h2301;
  // Baud codes 0..6 = 20,50,125,250,500,800,1000 kbit/s
  localparam logic [2:0] BAUD_DEF = 3'h2;
  localparam logic [2:0] BAUD_MAX = 3'h6;
  // Step codes 0..3 fixed steps, 4 free
  localparam logic [2:0] RES_FREE = 3'h4;
  localparam logic [2:0] PRES_DEF = 3'h2;
  localparam logic [2:0] VRES_DEF = 3'h0;
  localparam logic [31:0] PDIV_0 = 32'h0000000A;
  localparam logic [31:0] PDIV_1 = 32'h00000064;
  localparam logic [31:0] PDIV_2 = 32'h000003E8;
  localparam logic [31:0] PDIV_3 = 32'h00002710;
  localparam logic [31:0] VDIV_0 = 32'h000003E8;
  localparam logic [31:0] VDIV_1 = 32'h00002710;
  localparam logic [31:0] VDIV_2 = 32'h000186A0;
  localparam logic [31:0] VDIV_3 = 32'h000F4240;
  // Micrometres per mm and per inch/100
  localparam logic [31:0] UM_PER_MM = 32'h000003E8;
  localparam logic [31:0] UM_PER_CIN = 32'h000000FE;
  // Free resolution range and default, error delay and node defaults
  localparam logic [15:0] FREE_MIN = 16'h0005;
  localparam logic [15:0] FREE_MAX = 16'hC350;
  localparam logic [15:0] FREE_DEF = 16'h03E8;
  localparam logic [15:0] EDMS_DEF = 16'h0064;
  localparam logic [6:0] NODE_DEF = 7'h01;
  // Input functions
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_PRESET = 2'h1;
  localparam logic [1:0] FN_LASER = 2'h2;
  // Millisecond tick and divider step count
  localparam int CLK_NS = 50;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_NS;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  // Compute sequencer and error handling states
  typedef enum logic [2:0] {CS_IDLE = 3'b001, CS_POS = 3'b010, CS_VEL = 3'b100} poc_cs_t;
  typedef enum logic [2:0] {ES_OK = 3'b001, ES_HOLD = 3'b010, ES_SUBST = 3'b100} poc_es_t;
endpackage

// ==== verilog/poc_div.sv ====
// Purpose: sequential unsigned 32-bit divider, one quotient bit per cycle
// Assumes: divisor never zero
// Notes: done pulses one cycle with quot valid
`timescale 1ns/1ps
`default_nettype none
module poc_div (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic start, // Start pulse
  input wire logic [31:0] dividend, // Numerator
  input wire logic [31:0] divisor, // Denominator
  output logic done, // Result pulse
  output logic [31:0] quot // Quotient
);
  logic [32:0] rem_q, rem_d, trial;
  logic [31:0] quo_q, quo_d, div_q, div_d;
  logic [5:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done_q, done_d;

  // Next state of the shift-subtract loop
  always_comb begin
    rem_d = rem_q;
    quo_d = quo_q;
    div_d = div_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    trial = {rem_q[31:0], quo_q[31]};
    if (start) begin
      rem_d = 33'h000000000;
      quo_d = dividend;
      div_d = divisor;
      cnt_d = poc_pkg::DIV_STEPS;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (trial >= {1'b0, div_q}) begin
        rem_d = trial - {1'b0, div_q};
        quo_d = {quo_q[30:0], 1'b1};
      end else begin
        rem_d = trial;
        quo_d = {quo_q[30:0], 1'b0};
      end
      cnt_d = cnt_q - 6'h01;
      if (cnt_q == 6'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= 33'h000000000;
      quo_q <= 32'h00000000;
      div_q <= 32'h00000001;
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      rem_q <= rem_d;
      quo_q <= quo_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
  assign quot = quo_q;
endmodule // poc_div
`default_nettype wire

// ==== sim/poc_checker.sv ====
// Purpose: port checks for the position output block
// Assumes: one clock, async low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module poc_checker (
  input wire logic MCLK, // Clock
  input wire logic RESET_N, // Reset, low
  input wire logic CE, // Clock enable
  input wire logic PAR_WR, // Write strobe
  input wire logic PAR_BUS, // Bus source
  input wire logic [4:0] PAR_ID, // Id
  input wire logic [31:0] PAR_DATA, // Value
  input wire logic MEAS_VALID, // Sample strobe
  input wire logic MEAS_ERR, // Bad sample
  input wire logic OUT_VALID, // New output
  input wire logic POS_ERR, // Error handling
  input wire logic PAR_EN, // Enable flag
  input wire logic PW_OK, // Password matched
  input wire logic PAR_REJ, // Refused
  input wire logic LANG_EN, // Defaults done
  input wire logic [2:0] BAUD_SEL, // Rate code
  input wire logic [6:0] NODE_ID, // Node address
  input wire logic BUS_ACT, // Bus on
  input wire logic UNIT_INCH // Inch unit
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////
  // Write acceptance and refusal
  lock_menu_a: assert property (CE && PAR_WR && !PAR_BUS && !PAR_EN && PAR_ID == poc_pkg::ID_BAUD |=> PAR_REJ)
    else $error("locked menu write taken");
  baud_range_a: assert property (CE && PAR_WR && PAR_ID == poc_pkg::ID_BAUD && PAR_DATA > 32'h6 |=> PAR_REJ)
    else $error("bad rate code taken");
  baud_cause_a: assert property ($changed(BAUD_SEL) |-> $past(PAR_WR && CE))
    else $error("rate changed without write");
  pw_session_a: assert property (!PAR_EN |=> !PW_OK)
    else $error("password held while disabled");
  bus_take_a: assert property (CE && PAR_WR && PAR_BUS && (PAR_ID == poc_pkg::ID_OFFS || PAR_ID == poc_pkg::ID_DIR)
    |=> !PAR_REJ)
    else $error("bus write refused");
  dflt_vals_a: assert property (LANG_EN |-> BAUD_SEL == 3'h2 && NODE_ID == 7'h01 && BUS_ACT && !UNIT_INCH)
    else $error("defaults not restored");
  node_range_a: assert property (NODE_ID != 7'h00)
    else $error("node address zero");
  ////////////////////////////////////////
  // Measurement output
  err_cause_a: assert property ($rose(POS_ERR) |-> $past(CE && MEAS_VALID && MEAS_ERR))
    else $error("error state without bad sample");
  outv_pulse_a: assert property (OUT_VALID |=> !OUT_VALID [*8])
    else $error("output strobe too close");
  c_dflt: cover property (LANG_EN);
  c_rej: cover property (PAR_REJ);
  c_err: cover property ($rose(POS_ERR));
  c_out: cover property (OUT_VALID);
endmodule // poc_checker
`default_nettype wire

// ==== sim/poc_bus_master.sv ====
// Purpose: field-bus master and panel writer model
// Assumes: writes are one-cycle strobes
// Notes: keeps the last position it read
`timescale 1ns/1ps
`default_nettype none
module poc_bus_master (
  input wire logic MCLK, // Clock
  input wire logic OUT_VALID, // New output
  input wire logic [31:0] POS_OUT, // Position
  output logic PAR_WR, // Write strobe
  output logic PAR_BUS, // Bus source
  output logic [4:0] PAR_ID, // Id
  output logic [31:0] PAR_DATA, // Value
  output logic [31:0] last_pos // Last read position
);
  // Idle; no write strobe, id 1F until the first write
  initial begin
    PAR_WR = 1'b0;
    PAR_BUS = 1'b0;
    PAR_ID = 5'h1F;
    PAR_DATA = 32'h0;
  end
  // Read the position on every new value
  always @(posedge MCLK) begin
    if (OUT_VALID === 1'b1) last_pos <= POS_OUT;
  end
  // One write, held over exactly one taking edge
  task automatic wr(input logic b, input logic [4:0] id, input logic [31:0] d);
    @(posedge MCLK);
    #1;
    PAR_WR = 1'b1;
    PAR_BUS = b;
    PAR_ID = id;
    PAR_DATA = d;
    @(posedge MCLK);
    #1;
    PAR_WR = 1'b0;
    PAR_ID = ~id;
    PAR_DATA = ~d;
  endtask
endmodule // poc_bus_master
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the position output block
// Assumes: millisecond tick shortened to 4 cycles
// Notes: writes go through the bus master model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic MCLK, RESET_N, CE, MEAS_VALID, MEAS_ERR;
  logic [31:0] MEAS_DIST, MEAS_VEL;
  logic [1:0] SW_IN;
  wire logic PAR_WR, PAR_BUS, OUT_VALID, POS_ERR, PAR_EN, PW_OK, PAR_REJ, LANG_EN, BUS_ACT, UNIT_INCH, LASER_ON;
  wire logic [4:0] PAR_ID;
  wire logic [31:0] PAR_DATA, POS_OUT, VEL_OUT, bm_pos;
  wire logic [2:0] BAUD_SEL;
  wire logic [6:0] NODE_ID;
  int err_total = 0;
  int total_checks = 0;
  poc_top #(.TICK_CYC(4)) dut_u (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .PAR_WR(PAR_WR), .PAR_BUS(PAR_BUS),
    .PAR_ID(PAR_ID), .PAR_DATA(PAR_DATA), .MEAS_VALID(MEAS_VALID), .MEAS_ERR(MEAS_ERR), .MEAS_DIST(MEAS_DIST),
    .MEAS_VEL(MEAS_VEL), .SW_IN(SW_IN), .POS_OUT(POS_OUT), .VEL_OUT(VEL_OUT), .OUT_VALID(OUT_VALID),
    .POS_ERR(POS_ERR), .PAR_EN(PAR_EN), .PW_OK(PW_OK), .PAR_REJ(PAR_REJ), .LANG_EN(LANG_EN), .BAUD_SEL(BAUD_SEL),
    .NODE_ID(NODE_ID), .BUS_ACT(BUS_ACT), .UNIT_INCH(UNIT_INCH), .LASER_ON(LASER_ON));
  poc_bus_master bm_u (.MCLK(MCLK), .OUT_VALID(OUT_VALID), .POS_OUT(POS_OUT), .PAR_WR(PAR_WR), .PAR_BUS(PAR_BUS),
    .PAR_ID(PAR_ID), .PAR_DATA(PAR_DATA), .last_pos(bm_pos));
  ////////////////////////////////////////
  // Clock
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Write, then judge the refusal flag
  task automatic wrc(input logic b, input logic [4:0] id, input logic [31:0] d, input logic rej);
    bm_u.wr(b, id, d);
    chk(32'(PAR_REJ), 32'(rej));
  endtask
  // One sample; good ones wait for the result
  task automatic meas(input logic e, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    #1;
    MEAS_VALID = 1'b1;
    MEAS_ERR = e;
    MEAS_DIST = d;
    MEAS_VEL = 32'h1388;
    @(posedge MCLK);
    #1;
    MEAS_VALID = 1'b0;
    MEAS_DIST = ~d;
    while (!e && OUT_VALID !== 1'b1) begin
      @(posedge MCLK);
      #1;
      n++;
      if (n > 200) begin
        chk(32'(n), 32'hC8);
        finish_test();
      end
    end
  endtask
  task automatic pos(input logic [31:0] d, input logic [31:0] e);
    meas(1'b0, d);
    chk(POS_OUT, e);
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic t_lock();
    chk(32'(BAUD_SEL), 32'h2);
    chk({NODE_ID, BUS_ACT, UNIT_INCH, PAR_EN, LASER_ON}, 32'h19);
    wrc(0, poc_pkg::ID_BAUD, 32'h6, 1);
    wrc(0, poc_pkg::ID_PWON, 32'h1, 1);
    wrc(0, poc_pkg::ID_PEN, 32'h1, 0);
    wrc(0, poc_pkg::ID_BAUD, 32'h9, 1);
    for (int b = 0; b < 7; b++) begin
      wrc(0, poc_pkg::ID_BAUD, 32'(b), 0);
      chk(32'(BAUD_SEL), 32'(b));
    end
  endtask
  task automatic t_pw();
    wrc(0, poc_pkg::ID_PWON, 32'h1, 0);
    for (int i = 0; i < 4; i++) wrc(0, poc_pkg::ID_PWDIG, 32'(i * 16 + i + 1), 0);
    bm_u.wr(0, poc_pkg::ID_PEN, 32'h0);
    wrc(0, poc_pkg::ID_PEN, 32'h1, 0);
    wrc(0, poc_pkg::ID_BAUD, 32'h4, 1);
    wrc(0, poc_pkg::ID_UNLOCK, 32'h1234, 1);
    wrc(0, poc_pkg::ID_UNLOCK, 32'h4321, 0);
    chk(32'(PW_OK), 32'h1);
    bm_u.wr(0, poc_pkg::ID_PEN, 32'h0);
    bm_u.wr(0, poc_pkg::ID_PEN, 32'h1);
    wrc(0, poc_pkg::ID_UNLOCK, 32'h2301, 0);
    wrc(0, poc_pkg::ID_BAUD, 32'h4, 0);
    bm_u.wr(0, poc_pkg::ID_DEFLT, 32'h0);
    chk({LANG_EN, 1'b0, BAUD_SEL}, 32'h12);
    bm_u.wr(0, poc_pkg::ID_PEN, 32'h1);
  endtask
  task automatic t_pos();
    pos(32'h3039, 32'hC);
    chk(VEL_OUT, 32'h5);
    @(posedge MCLK);
    #1;
    chk(bm_pos, 32'hC);
    wrc(1, poc_pkg::ID_OFFS, 32'h3, 0);
    pos(32'h3039, 32'hF);
    wrc(1, poc_pkg::ID_DIR, 32'h1, 0);
    pos(32'h3039, 32'hFFFFFFF7);
    bm_u.wr(1, poc_pkg::ID_DIR, 32'h0);
    bm_u.wr(1, poc_pkg::ID_OFFS, 32'h0);
    wrc(1, poc_pkg::ID_FREE, 32'h4, 1);
    wrc(1, poc_pkg::ID_FREE, 32'hC351, 1);
    wrc(1, poc_pkg::ID_FREE, 32'h36B, 0);
    for (int s = 0; s < 4; s++) begin
      bm_u.wr(0, poc_pkg::ID_PRES, 32'(s));
      pos(32'h1E240, 32'h1E240 / (32'hA * 32'hA ** s));
    end
    bm_u.wr(0, poc_pkg::ID_PRES, 32'h4);
    pos(32'h1E240, 32'h8D);
    bm_u.wr(0, poc_pkg::ID_PRES, 32'h2);
    wrc(1, poc_pkg::ID_UNIT, 32'h1, 0);
    pos(32'h1E240, 32'h1E6);
    bm_u.wr(1, poc_pkg::ID_UNIT, 32'h0);
  endtask
  task automatic t_err();
    for (int s = 1; s >= 0; s--) begin
      bm_u.wr(1, poc_pkg::ID_ESUB, 32'(s));
      pos(32'h3039, 32'hC);
      meas(1'b1, 32'h0);
      chk(32'(POS_ERR), 32'h1);
      chk(POS_OUT, 32'hC);
      repeat (390) @(posedge MCLK);
      chk(POS_OUT, 32'hC);
      repeat (40) @(posedge MCLK);
      chk(POS_OUT, s ? 32'hC : 32'h0);
    end
    pos(32'h3039, 32'hC);
    chk(32'(POS_ERR), 32'h0);
    bm_u.wr(1, poc_pkg::ID_EDON, 32'h0);
    meas(1'b1, 32'h0);
    repeat (2) @(posedge MCLK);
    chk(POS_OUT, 32'h0);
  endtask
  task automatic t_laser();
    wrc(0, poc_pkg::ID_IN0, 32'h2, 0);
    chk(32'(LASER_ON), 32'h1);
    CE = 1'b0;
    SW_IN = 2'h2;
    repeat (3) @(posedge MCLK);
    #1;
    chk(32'(LASER_ON), 32'h1);
    CE = 1'b1;
    repeat (3) @(posedge MCLK);
    #1;
    chk(32'(LASER_ON), 32'h0);
    SW_IN = 2'h3;
  endtask
  // Teach on input 1 loads the preset, which then outranks the offset
  task automatic t_teach();
    wrc(1, poc_pkg::ID_PRESET, 32'h5, 0);
    wrc(0, poc_pkg::ID_IN1, 32'h1, 0);
    SW_IN = 2'h1;
    pos(32'h3039, 32'h5);
    wrc(1, poc_pkg::ID_OFFS, 32'h3, 0);
    pos(32'h3039, 32'h5);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    RESET_N = 1'b0;
    CE = 1'b1;
    MEAS_VALID = 1'b0;
    MEAS_ERR = 1'b0;
    MEAS_DIST = 32'h0;
    MEAS_VEL = 32'h0;
    SW_IN = 2'h3;
    repeat (5) @(posedge MCLK);
    #1;
    RESET_N = 1'b1;
    t_lock();
    t_pw();
    t_pos();
    t_laser();
    t_err();
    t_teach();
    finish_test();
  end
endmodule // tb
bind poc_top poc_checker chk_u (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .PAR_WR(PAR_WR), .PAR_BUS(PAR_BUS),
  .PAR_ID(PAR_ID), .PAR_DATA(PAR_DATA), .MEAS_VALID(MEAS_VALID), .MEAS_ERR(MEAS_ERR), .OUT_VALID(OUT_VALID),
  .POS_ERR(POS_ERR), .PAR_EN(PAR_EN), .PW_OK(PW_OK), .PAR_REJ(PAR_REJ), .LANG_EN(LANG_EN), .BAUD_SEL(BAUD_SEL),
  .NODE_ID(NODE_ID), .BUS_ACT(BUS_ACT), .UNIT_INCH(UNIT_INCH));
`default_nettype wire
